// ==== ebwi_consts.vh ====
// constants for the external bus wait interface
`ifndef EBWI_CONSTS_VH
`define EBWI_CONSTS_VH
// register byte offsets on the axi4-lite slave
`define EBWI_BANKCTL_OFS 8'h00
`define EBWI_WAIT_OFS 8'h04
`define EBWI_CMD_OFS 8'h08
`define EBWI_WDATA_OFS 8'h0c
`define EBWI_STAT_OFS 8'h10
`define EBWI_RDATA_OFS 8'h14
// control register fields
`define EBWI_DIV_LSB 0
`define EBWI_B2B_BIT 2
`define EBWI_BANKCTL_RST 32'h0000_0003
// divide codes
`define EBWI_DIV_1 2'b00
`define EBWI_DIV_2 2'b01
`define EBWI_DIV_4 2'b11
// wait register fields: program, data, io counts, 3 bits each
`define EBWI_WS_W 3
`define EBWI_WAIT_RST 32'h0000_0000
// command fields
`define EBWI_CMD_ADDR_W 16
`define EBWI_CMD_WR_BIT 16
`define EBWI_CMD_SP_LSB 17
// spaces
`define EBWI_SP_PROG 2'b00
`define EBWI_SP_DATA 2'b01
`define EBWI_SP_IO 2'b10
// least software wait count for ready use
`define EBWI_RDY_MIN_WS 3'd2
// axi responses
`define EBWI_RESP_OKAY 2'b00
`define EBWI_RESP_SLVERR 2'b10
`endif

// ==== ebwi_sync2.v ====
// two flip-flop synchroniser for a single level
module ebwi_sync2 (
  input wire clock_in,
  input wire sys_rst_in,
  input wire d_in,
  output wire q_out
);
  reg meta_r; // first stage, read only by second stage
  reg q_r; // stable stage
  // plain two stage chain; resets to high (bus idle)
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= 1'b1;
      q_r <= 1'b1;
    end else begin
      meta_r <= d_in;
      q_r <= meta_r;
    end
  end
  assign q_out = q_r;
endmodule

// ==== ebwi_clkdiv.v ====
// bus output clock generator with programmable divide
`include "ebwi_consts.vh"
module ebwi_clkdiv (
  input wire clock_in,
  input wire sys_rst_in,
  input wire [1:0] div_in,
  output wire fall_out,
  output wire clk_out
);
  reg [1:0] cnt_r; // phase counter
  reg clk_r; // output clock level
  reg [1:0] lim; // half period minus one, in core cycles
  // 00 gives core/2 (undivided), 01 /2 more, else /4
  always @* begin
    case (div_in)
      `EBWI_DIV_1: lim = 2'd0; // [R10]
      `EBWI_DIV_2: lim = 2'd1;
      default: lim = 2'd3;
    endcase
  end
  // toggle the output clock at the end of each half period
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r <= 2'd0;
      clk_r <= 1'b1;
    end else if (cnt_r >= lim) begin
      cnt_r <= 2'd0;
      clk_r <= ~clk_r;
    end else begin
      cnt_r <= cnt_r + 2'd1;
    end
  end
  // strobe one core cycle wide when a falling edge is issued
  assign fall_out = clk_r && (cnt_r >= lim);
  assign clk_out = clk_r;
endmodule

// ==== ebwi_top.v ====
// external bus wait interface with axi4-lite control
`include "ebwi_consts.vh"
// Contract
// R1 - back-to-back or isolated reads by control bit
// R2 - io space uses the io strobe
// R3 - direction and selects change with address
// R4 - capture read data at output clock fall
// R5 - ready extends only software-waited cycles
// R6 - software programs two waits for ready
// R7 - ready ignored until software waits done
// R8 - ready sampled at output clock falls
// R9 - status output toggles at clock falls
// R10 - divide 00 undivided, reset divides four
// R11 - ready low holds strobe, adds wait
module ebwi_top (
  input wire clock_in,
  input wire sys_rst_in,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [15:0] bus_addr_out,
  output reg [15:0] bus_data_out,
  output reg bus_data_oe_out,
  input wire [15:0] bus_data_in,
  output reg bus_rw_out,
  output reg memory_strobe_n_out,
  output reg io_strobe_n_out,
  output reg program_space_select_out,
  output reg data_space_select_out,
  output reg io_space_select_out,
  input wire ready_in,
  output reg cycle_complete_status_n_out,
  output reg bus_output_clock_out
);
  // phase states, each lasting one or more output clock periods
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_STRB = 3'd2;
  localparam ST_SWW = 3'd3;
  localparam ST_HWW = 3'd4;
  localparam ST_DONE = 3'd5;

  reg [31:0] bank_switch_control_reg_r; // divide and read mode
  reg [31:0] wait_r; // software wait counts per space
  reg [31:0] wdata_r; // pending write data
  reg [31:0] cmd_r; // latched command
  reg go_r; // command pending
  reg busy_r; // cycle in progress
  reg [15:0] rdata_r; // captured read data
  reg [2:0] st_r; // bus sequencer state
  reg [2:0] wcnt_r; // software waits left
  reg prev_rd_r; // last cycle was a read
  reg [1:0] prev_sp_r; // its space
  reg rdy_fault_r; // ready used with too few waits
  wire [1:0] div_w; // divide field
  wire fall_w; // output clock falls this cycle
  wire clk_w; // divided clock level
  wire rdy_s; // synchronised ready
  wire [15:0] data_s; // data lines after the two-stage synchronisers
  wire [1:0] sp_w; // command space
  wire cmd_wr; // command is a write
  reg [2:0] ws_w; // software waits for the space
  wire b2b_w; // back-to-back read allowed
  wire cap_w; // this fall is a read capture point
  reg [1:0] cap_r; // capture point delayed past the synchroniser

  assign div_w = bank_switch_control_reg_r[`EBWI_DIV_LSB +: 2];
  assign sp_w = cmd_r[`EBWI_CMD_SP_LSB +: 2];
  assign cmd_wr = cmd_r[`EBWI_CMD_WR_BIT];
  // back-to-back only for a read following a read in the same space
  assign b2b_w = bank_switch_control_reg_r[`EBWI_B2B_BIT] &&
    prev_rd_r && !cmd_wr && (prev_sp_r == sp_w); // [R1]
  // falls at which the sequencer ends the strobe of a cycle
  assign cap_w = fall_w && (((st_r == ST_STRB) && (wcnt_r == 3'd0)) ||
    ((st_r == ST_SWW) && (wcnt_r == 3'd0) && rdy_s) ||
    ((st_r == ST_HWW) && rdy_s));

  // wait count picks by space
  always @* begin
    case (sp_w)
      `EBWI_SP_PROG: ws_w = wait_r[2:0];
      `EBWI_SP_DATA: ws_w = wait_r[5:3];
      default: ws_w = wait_r[8:6];
    endcase
  end

  ebwi_clkdiv u_div (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .div_in(div_w),
    .fall_out(fall_w),
    .clk_out(clk_w)
  );
  ebwi_sync2 u_rdy (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .d_in(ready_in),
    .q_out(rdy_s)
  );
  // data lines synchronised bit by bit
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_dsync
      ebwi_sync2 u_ds (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .d_in(bus_data_in[gi]),
        .q_out(data_s[gi])
      );
    end
  endgenerate

  // output clock retimed to a flip-flop
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_output_clock_out <= 1'b1;
    end else begin
      bus_output_clock_out <= clk_w;
    end
  end

  // read capture: the pins seen at a capture fall reach data_s two
  // cycles later, so the capture waits as long; without this a
  // zero-wait read at the undivided clock would take released-bus junk
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cap_r <= 2'b00;
      rdata_r <= 16'h0000;
    end else begin
      cap_r <= {cap_r[0], cap_w};
      if (cap_r[1]) begin
        rdata_r <= data_s; // [R4]
      end
    end
  end

  // bus sequencer: every step happens at an output clock fall
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= ST_IDLE;
      wcnt_r <= 3'd0;
      busy_r <= 1'b0;
      prev_rd_r <= 1'b0;
      prev_sp_r <= 2'b00;
      rdy_fault_r <= 1'b0;
      bus_addr_out <= 16'h0000;
      bus_data_out <= 16'h0000;
      bus_data_oe_out <= 1'b0;
      bus_rw_out <= 1'b1;
      memory_strobe_n_out <= 1'b1;
      io_strobe_n_out <= 1'b1;
      program_space_select_out <= 1'b0;
      data_space_select_out <= 1'b0;
      io_space_select_out <= 1'b0;
      cycle_complete_status_n_out <= 1'b1;
    end else if (fall_w) begin
      case (st_r)
        ST_IDLE: begin
          if (go_r) begin
            busy_r <= 1'b1;
            // address, direction and selects move together
            bus_addr_out <= cmd_r[15:0]; // [R3]
            bus_rw_out <= ~cmd_wr; // [R3]
            program_space_select_out <= (sp_w == `EBWI_SP_PROG); // [R3]
            data_space_select_out <= (sp_w == `EBWI_SP_DATA); // [R3]
            io_space_select_out <= (sp_w == `EBWI_SP_IO); // [R3]
            bus_data_out <= wdata_r[15:0];
            bus_data_oe_out <= cmd_wr;
            wcnt_r <= ws_w;
            // consecutive read skips the address setup period
            if (b2b_w) begin // [R1]
              if (sp_w == `EBWI_SP_IO) io_strobe_n_out <= 1'b0;
              else memory_strobe_n_out <= 1'b0;
              st_r <= ST_STRB;
            end else begin
              st_r <= ST_ADDR;
            end
          end else begin
            busy_r <= 1'b0;
          end
        end
        ST_ADDR: begin
          // io space uses its own strobe
          if (sp_w == `EBWI_SP_IO) io_strobe_n_out <= 1'b0; // [R2]
          else memory_strobe_n_out <= 1'b0; // [R2]
          st_r <= ST_STRB;
        end
        ST_STRB: begin
          if (wcnt_r != 3'd0) begin
            wcnt_r <= wcnt_r - 3'd1;
            st_r <= ST_SWW;
          end else begin
            // no software waits: ready never consulted
            st_r <= ST_DONE; // [R5]
            memory_strobe_n_out <= 1'b1;
            io_strobe_n_out <= 1'b1;
          end
        end
        ST_SWW: begin
          if (wcnt_r != 3'd0) begin
            wcnt_r <= wcnt_r - 3'd1; // [R7]
          end else if (!rdy_s) begin
            // hardware wait: hold everything, mark the extension
            if (ws_w < `EBWI_RDY_MIN_WS) rdy_fault_r <= 1'b1; // [R6]
            cycle_complete_status_n_out <= 1'b0; // [R9]
            st_r <= ST_HWW; // [R8] [R11]
          end else begin
            memory_strobe_n_out <= 1'b1;
            io_strobe_n_out <= 1'b1;
            st_r <= ST_DONE;
          end
        end
        ST_HWW: begin
          if (rdy_s) begin // [R8]
            cycle_complete_status_n_out <= 1'b1; // [R9]
            memory_strobe_n_out <= 1'b1;
            io_strobe_n_out <= 1'b1;
            st_r <= ST_DONE;
          end
          // else one more wait, strobe and data held [R11]
        end
        ST_DONE: begin
          prev_rd_r <= ~cmd_wr;
          prev_sp_r <= sp_w;
          bus_data_oe_out <= 1'b0;
          busy_r <= 1'b0;
          st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // axi4-lite write channel; registers decode once both halves taken
  reg [7:0] awa_r; // latched write address
  reg awh_r; // address held
  reg wh_r; // data held
  reg [31:0] wd_r; // latched write data
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EBWI_RESP_OKAY;
      awa_r <= 8'h00;
      awh_r <= 1'b0;
      wh_r <= 1'b0;
      wd_r <= 32'h0000_0000;
      bank_switch_control_reg_r <= `EBWI_BANKCTL_RST; // [R10]
      wait_r <= `EBWI_WAIT_RST;
      wdata_r <= 32'h0000_0000;
      cmd_r <= 32'h0000_0000;
      go_r <= 1'b0;
    end else begin
      // the sequencer consumes the command when it starts
      if (fall_w && st_r == ST_IDLE && go_r) go_r <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        awa_r <= s_axi_awaddr;
        awh_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_r <= s_axi_wdata;
        wh_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (awh_r && wh_r && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `EBWI_RESP_OKAY;
        case (awa_r)
          `EBWI_BANKCTL_OFS: bank_switch_control_reg_r <= wd_r & 32'h7;
          `EBWI_WAIT_OFS: wait_r <= wd_r & 32'h1ff;
          `EBWI_WDATA_OFS: wdata_r <= wd_r & 32'hffff;
          `EBWI_CMD_OFS: begin
            // a command while busy is refused
            if (go_r || busy_r) s_axi_bresp <= `EBWI_RESP_SLVERR;
            else begin
              cmd_r <= wd_r & 32'h7_ffff;
              go_r <= 1'b1;
            end
          end
          `EBWI_STAT_OFS, `EBWI_RDATA_OFS: ;
          default: s_axi_bresp <= `EBWI_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awh_r <= 1'b0;
        wh_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi4-lite read channel, one cycle answer
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `EBWI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `EBWI_RESP_OKAY;
      case (s_axi_araddr)
        `EBWI_BANKCTL_OFS: s_axi_rdata <= bank_switch_control_reg_r;
        `EBWI_WAIT_OFS: s_axi_rdata <= wait_r;
        `EBWI_CMD_OFS: s_axi_rdata <= cmd_r;
        `EBWI_WDATA_OFS: s_axi_rdata <= wdata_r;
        `EBWI_STAT_OFS: s_axi_rdata <= {26'h0, rdy_fault_r,
          ~cycle_complete_status_n_out, st_r, (busy_r | go_r)};
        `EBWI_RDATA_OFS: s_axi_rdata <= {16'h0000, rdata_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `EBWI_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// ==== ebwi_bus_monitor.sv ====
// assertion checker for the external bus side of the wait interface
module ebwi_bus_monitor (
  input wire clock_in,
  input wire sys_rst_in,
  input wire ready_in,
  input wire [15:0] bus_addr_out,
  input wire [15:0] bus_data_out,
  input wire bus_data_oe_out,
  input wire bus_rw_out,
  input wire memory_strobe_n_out,
  input wire io_strobe_n_out,
  input wire program_space_select_out,
  input wire data_space_select_out,
  input wire io_space_select_out,
  input wire cycle_complete_status_n_out,
  input wire bus_output_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // either strobe active
  wire stb_on = !memory_strobe_n_out || !io_strobe_n_out;
  wire [2:0] sel_all = {program_space_select_out, data_space_select_out,
    io_space_select_out};
  // two core cycles of hardware waiting in a row
  sequence s_hw_wait;
    !cycle_complete_status_n_out ##1 !cycle_complete_status_n_out;
  endsequence
  // output clock falls now or one cycle on, since it is registered late
  sequence s_bck_fall;
    ##[0:1] $fell(bus_output_clock_out);
  endsequence
  a_io_strobe: assert property (
    !io_strobe_n_out |-> io_space_select_out && memory_strobe_n_out)
    else $error("io strobe outside io space");
  a_mem_strobe: assert property (
    !memory_strobe_n_out |-> !io_space_select_out && sel_all != 3'h0)
    else $error("memory strobe without memory space");
  a_sel_idle: assert property (
    ($changed(bus_rw_out) || $changed(sel_all)) |-> !stb_on)
    else $error("select or direction moved under a strobe");
  a_addr_step: assert property (
    $changed(bus_addr_out) |-> s_bck_fall)
    else $error("address moved off an output clock fall");
  a_dir_drive: assert property (
    bus_data_oe_out |-> !bus_rw_out)
    else $error("data driven during a read");
  a_status_step: assert property (
    $changed(cycle_complete_status_n_out) |-> s_bck_fall)
    else $error("status moved off an output clock fall");
  a_hw_in_cycle: assert property (
    !cycle_complete_status_n_out |-> stb_on)
    else $error("hardware wait outside a bus cycle");
  a_hw_hold: assert property (
    s_hw_wait |-> stb_on && $stable(bus_addr_out) &&
      $stable(bus_data_out) && $stable(memory_strobe_n_out))
    else $error("cycle not held during hardware wait");
  a_ready_cause: assert property (
    $fell(cycle_complete_status_n_out) |->
      !$past(ready_in, 2) || !$past(ready_in, 3) || !$past(ready_in, 4))
    else $error("hardware wait without ready low");
endmodule

// ==== ebwi_ext_mem.sv ====
// external memory and io device model on the far side of the bus
module ebwi_ext_mem (
  input wire clock_in,
  input wire bck_in,
  input wire mstb_n_in,
  input wire iostb_n_in,
  input wire rw_in,
  input wire data_sel_in,
  input wire io_sel_in,
  input wire [15:0] addr_in,
  input wire [15:0] wdata_in,
  input int slow_in,
  output wire [15:0] rdata_out,
  output wire ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:1023];
  logic [15:0] last_r = 16'h0000;
  int hold_r = 0;
  logic was_r = 1'b0;
  wire act = !mstb_n_in || !iostb_n_in;
  wire [9:0] key = {io_sel_in, data_sel_in, addr_in[7:0]};
  // data steady through the strobe, inverted junk once released
  assign rdata_out = (act && rw_in) ? mem[key] : ~last_r;
  // ready only moves on output clock rises, so it is steady at falls
  assign ready_out = (hold_r == 0);
  always @(posedge bck_in) begin
    if (act && !was_r) hold_r <= slow_in;
    else if (hold_r != 0) hold_r <= hold_r - 1;
    was_r <= act;
  end
  // store writes, remember the last driven read word
  always @(posedge clock_in) begin
    if (act && !rw_in) mem[key] <= wdata_in;
    if (act && rw_in) last_r <= mem[key];
  end
endmodule

// ==== tb.sv ====
// self-checking bench for the external bus wait interface
`include "ebwi_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rnd = 32'd62;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] addr, dout, din;
  wire oe, rw, mstb_n, iostb_n, psel, dsel, isel, rdy, stat_n, bck;
  int slow = 0, err_total = 0, checks = 0, cyc = 0;
  int lo_cnt, io_cnt, m_cnt;
  logic [1:0] wr_resp = 2'b00;
  int exp_mem [int];
  ebwi_top i_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bus_addr_out(addr), .bus_data_out(dout),
    .bus_data_oe_out(oe), .bus_data_in(din), .bus_rw_out(rw),
    .memory_strobe_n_out(mstb_n), .io_strobe_n_out(iostb_n),
    .program_space_select_out(psel), .data_space_select_out(dsel),
    .io_space_select_out(isel), .ready_in(rdy),
    .cycle_complete_status_n_out(stat_n), .bus_output_clock_out(bck));
  ebwi_ext_mem i_mem (.clock_in(clock_in), .bck_in(bck),
    .mstb_n_in(mstb_n), .iostb_n_in(iostb_n), .rw_in(rw),
    .data_sel_in(dsel), .io_sel_in(isel), .addr_in(addr),
    .wdata_in(dout), .slow_in(slow), .rdata_out(din), .ready_out(rdy));
  initial begin
    forever #2 clock_in = ~clock_in;
  end
  // ceiling sits well above the thousand or fewer cycles the tests need
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (!stat_n) lo_cnt++;
    if (!iostb_n) io_cnt++;
    if (!mstb_n) m_cnt++;
    if (cyc == 60000) begin
      err_total++;
      complete_run();
    end
  end
  task complete_run;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  // write: offer address and data together, release each when taken
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clock_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    @(posedge clock_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // core cycles from one output clock rise to the next
  task per(output int n);
    n = 0;
    while (bck !== 1'b0) @(posedge clock_in);
    while (bck !== 1'b1) @(posedge clock_in);
    do begin @(posedge clock_in); n++; end while (bck !== 1'b0);
    do begin @(posedge clock_in); n++; end while (bck !== 1'b1);
  endtask
  task ws(input [2:0] n);
    wr(`EBWI_WAIT_OFS, {23'h0, n, n, n});
  endtask
  // one bus cycle through the command register, checked on return
  task op(input [1:0] sp, input w, input [15:0] a, output int dur);
    logic [31:0] d;
    logic [1:0] r;
    int key;
    key = {sp, a[7:0]};
    if (w) begin
      d = xs();
      exp_mem[key] = d[15:0];
      wr(`EBWI_WDATA_OFS, d);
    end
    lo_cnt = 0;
    io_cnt = 0;
    m_cnt = 0;
    dur = cyc;
    wr(`EBWI_CMD_OFS, {13'h0, sp, w, a});
    do rd(`EBWI_STAT_OFS, d, r); while (d[0] !== 1'b0);
    dur = cyc - dur;
    chk(io_cnt != 0, sp == `EBWI_SP_IO);
    chk(m_cnt != 0, sp != `EBWI_SP_IO);
    if (!w) begin
      rd(`EBWI_RDATA_OFS, d, r);
      chk(d[15:0], exp_mem[key]);
    end
  endtask
  initial begin
    int p, d1, d2;
    logic [31:0] v;
    logic [1:0] r, sp;
    logic [15:0] a;
    repeat (12) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd(`EBWI_BANKCTL_OFS, v, r);
    chk(v, `EBWI_BANKCTL_RST);
    per(p);
    chk(p, 8);
    wr(`EBWI_BANKCTL_OFS, 32'h1);
    per(p);
    per(p);
    chk(p, 4);
    wr(`EBWI_BANKCTL_OFS, 32'h0);
    per(p);
    per(p);
    chk(p, 2);
    rd(8'h1c, v, r);
    chk(r, `EBWI_RESP_SLVERR);
    wr(8'h1c, 32'h0);
    chk(wr_resp, `EBWI_RESP_SLVERR);
    $display("clock divide test done");
    for (int i = 0; i < 6; i++) begin
      sp = 2'(i % 3);
      a = 16'(xs());
      ws(3'(i));
      op(sp, 1'b1, a, d1);
      op(sp, 1'b0, a, d1);
    end
    $display("space and wait test done");
    // ready low inside the software waits, or with no software waits, is ignored
    ws(3'd3);
    slow = 1;
    op(sp, 1'b0, a, d1);
    chk(lo_cnt, 0);
    ws(3'd0);
    slow = 6;
    op(sp, 1'b0, a, d1);
    chk(lo_cnt, 0);
    ws(3'd2); // software keeps two waits when ready is used
    op(sp, 1'b0, a, d1);
    chk(lo_cnt != 0, 1);
    slow = 0;
    $display("ready test done");
    // slow divide makes the skipped address phase easy to see
    ws(3'd1);
    wr(`EBWI_BANKCTL_OFS, 32'h3);
    op(2'b00, 1'b1, a, d1);
    op(2'b00, 1'b0, a, d1);
    op(2'b00, 1'b0, a, d1);
    wr(`EBWI_BANKCTL_OFS, 32'h7);
    op(2'b00, 1'b0, a, d2);
    op(2'b00, 1'b0, a, d2);
    chk(d2 < d1, 1);
    $display("back to back test done");
    // a second command while the first still runs is refused
    wr(`EBWI_CMD_OFS, {13'h0, 2'b01, 1'b0, a});
    chk(wr_resp, `EBWI_RESP_OKAY);
    wr(`EBWI_CMD_OFS, {13'h0, 2'b01, 1'b0, a});
    chk(wr_resp, `EBWI_RESP_SLVERR);
    $display("command refusal test done");
    complete_run();
  end
endmodule
bind ebwi_top ebwi_bus_monitor i_mon (.clock_in(clock_in),
  .sys_rst_in(sys_rst_in), .ready_in(ready_in),
  .bus_addr_out(bus_addr_out), .bus_data_out(bus_data_out),
  .bus_data_oe_out(bus_data_oe_out), .bus_rw_out(bus_rw_out),
  .memory_strobe_n_out(memory_strobe_n_out),
  .io_strobe_n_out(io_strobe_n_out),
  .program_space_select_out(program_space_select_out),
  .data_space_select_out(data_space_select_out),
  .io_space_select_out(io_space_select_out),
  .cycle_complete_status_n_out(cycle_complete_status_n_out),
  .bus_output_clock_out(bus_output_clock_out));
